// >>> logic/dpe_ecc_ctrl.sv
/*
 * dual-port ecc ram controller: two bus ports, arbiter, secded array, mode and log i/o port.
 * assumes all inputs synchronous to clock; masters hold cmd stable from req pulse to ack.
 */
// Functional notes
// - store check bits, fix single-bit errors, flag double and most multi-bit errors.
// - mode register and error log share one i/o port; write mode, read log.
// - straps pick one of nine preset i/o addresses; spare entries take a custom address.
// - six modes; either interrupt policy combines with correcting or non-correcting.
// - any-error policy interrupts on single-bit and multi-bit errors.
// - uncorrectable policy interrupts only on multi-bit errors.
// - correcting mode returns fixed data; uncorrectable data passes unchanged.
// - non-correcting mode still checks and interrupts but never alters read data.
// - diagnostic mode never writes the check-bit array.
// - examine mode logs syndrome on reads and generated check bits on writes.
// - examine mode bypasses log translation, raw word appears.
// - eight-bit log overwritten on each error, showing the latest one.
// - log bits 6:5 give the failing row in binary.
// - log bits 4:0 name data bit, check bit, or all ones for uncorrectable.
// - log bit 7 always reads one.
// - low memory protect blocks every array access not yet granted.
// - system port decodes page, then 16k block base within it.
// - local port decodes a 64k block base in a flat space.
// - both ports decode from independent base settings.
// - byte and word transfers with 24-bit addresses on both ports.
// - a read that finds an error waits longer before its ack.
`timescale 1ns/1ps
module dpe_ecc_ctrl
    import dpe_pkg::*;
#(
    parameter int WORD_BITS = 8,
    parameter logic [15:0] SPARE_IO_ADDR = 16'h00f0
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // system bus port
    input wire logic sys_req,
    input wire dpe_req_type sys_cmd,
    input wire logic [1:0] sys_page,
    input wire logic [7:0] sys_base,
    output logic sys_ack,
    output logic [15:0] sys_rdata,
    // local bus port
    input wire logic lcl_req,
    input wire dpe_req_type lcl_cmd,
    input wire logic [7:0] lcl_base,
    output logic lcl_ack,
    output logic [15:0] lcl_rdata,
    // ecc i/o port
    input wire logic [3:0] io_sel,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic io_ack,
    output logic [7:0] io_rdata,
    // protect and interrupt
    input wire logic mprot_b,
    output logic err_irq
);
    localparam int DEPTH = 1 << WORD_BITS;
    localparam logic [23:0] MEM_BYTES = 24'(2 * DEPTH);
    localparam int CW = $clog2(DPE_ERR_CYC + 1);

    generate
        if (WORD_BITS < 2 || WORD_BITS > 22) begin : g_bad
            $error("WORD_BITS must lie in 2..22");
        end
    endgenerate

    typedef struct packed {
        dpe_st_type st;
        logic [1:0] pend;
        logic grant_lcl;
        logic last_lcl;
        dpe_req_type req;
        logic [WORD_BITS-1:0] idx;
        logic [CW-1:0] cnt;
        dpe_mode_type mode;
        logic [6:0] log;
        logic irq;
        logic sys_ack;
        logic lcl_ack;
        logic io_ack;
        logic [15:0] rdata;
        logic [7:0] io_rdata;
        dpe_word_type [DEPTH-1:0] mem;
    } dpe_state_type;

    dpe_state_type cur;
    dpe_state_type next_cur;

    // hamming check bits plus overall parity in bit 5
    function automatic logic [5:0] dpe_check(input logic [15:0] d);
        logic [5:0] c;
        c = '0;
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 5; k++) begin
                if (DPE_POS[i][k]) begin
                    c[k] = c[k] ^ d[i];
                end
            end
        end
        c[5] = ^{d, c[4:0]};
        return c;
    endfunction

    // syndrome to log code; even parity with nonzero syndrome is a double error
    function automatic logic [4:0] dpe_decode(input logic [5:0] s);
        logic [4:0] code;
        code = DPE_CODE_UNC;
        if (s == '0) begin
            code = DPE_CODE_NOERR;
        end else if (s[5]) begin
            if (s[4:0] == '0) begin
                code = DPE_CODE_PAR;
            end
            for (int k = 0; k < 5; k++) begin
                if (s[4:0] == 5'(1 << k)) begin
                    code = DPE_CODE_CHK | 5'(k);
                end
            end
            for (int i = 0; i < 16; i++) begin
                if (DPE_POS[i] == s[4:0]) begin
                    code = 5'(i);
                end
            end
        end
        return code;
    endfunction

    // window hit against a base, used by both ports
    function automatic logic dpe_hit(input logic [23:0] a, input logic [23:0] base);
        logic [23:0] off;
        off = a - base;
        return (a >= base) && (off < MEM_BYTES);
    endfunction

    // word index of an address inside the window
    function automatic logic [WORD_BITS-1:0] dpe_index(input logic [23:0] a, input logic [23:0] base);
        logic [23:0] off;
        off = a - base;
        return off[WORD_BITS:1];
    endfunction

    logic [23:0] sys_win;
    logic [23:0] lcl_win;
    logic sys_hit;
    logic lcl_hit;
    logic [15:0] io_match;
    logic io_hit;
    dpe_word_type cur_word;
    logic [5:0] gen_rd;
    logic [5:0] syn;
    logic [4:0] code;
    logic rd_err;
    logic rd_unc;
    logic [15:0] fixed;
    logic [1:0] row;
    logic [15:0] merge_base;
    logic [15:0] new_data;
    logic [5:0] gen_wr;

    // independent windows per port
    assign sys_win = (24'(sys_page) << DPE_SYS_PAGE_LSB) | (24'(sys_base) << DPE_SYS_BLK_LSB);
    assign lcl_win = 24'(lcl_base) << DPE_LCL_BLK_LSB;
    assign sys_hit = dpe_hit(sys_cmd.addr, sys_win);
    assign lcl_hit = dpe_hit(lcl_cmd.addr, lcl_win);
    // straps beyond the presets fall to the spare address
    assign io_match = (io_sel < 4'(DPE_IO_PRESETS)) ? DPE_IO_TABLE[io_sel] : SPARE_IO_ADDR;
    assign io_hit = (io_addr == io_match);

    // read-side check of the word under access
    assign cur_word = cur.mem[cur.idx];
    assign gen_rd = dpe_check(cur_word.data);
    assign syn = {^{cur_word.data, cur_word.chk}, cur_word.chk[4:0] ^ gen_rd[4:0]};
    assign code = dpe_decode(syn);
    assign rd_err = (code != DPE_CODE_NOERR);
    assign rd_unc = (code == DPE_CODE_UNC);
    assign fixed = (code < DPE_DATA_CODES) ? (cur_word.data ^ (16'h0001 << code)) : cur_word.data;
    assign row = cur.idx[WORD_BITS-1 -: 2];

    // byte writes merge into the stored word (corrected only in correcting mode), then regenerate
    assign merge_base = cur.mode.correct ? fixed : cur_word.data;
    assign new_data = !cur.req.byte_op ? cur.req.wdata :
                      cur.req.addr[0] ? {cur.req.wdata[15:8], merge_base[7:0]} :
                      {merge_base[15:8], cur.req.wdata[7:0]};
    assign gen_wr = dpe_check(new_data);

    // next-state logic
    always_comb begin
        next_cur = cur;
        next_cur.sys_ack = 1'b0;
        next_cur.lcl_ack = 1'b0;
        next_cur.io_ack = 1'b0;
        // i/o port: write steers mode, read returns log and drops irq
        if (io_wr && io_hit) begin
            next_cur.mode = io_wdata[3:0];
            next_cur.io_ack = 1'b1;
        end else if (io_rd && io_hit) begin
            next_cur.io_rdata = {1'b1, cur.log};
            next_cur.io_ack = 1'b1;
            next_cur.irq = 1'b0;
        end
        unique case (cur.st)
            DPE_ST_IDLE: begin
                // protect blocks any grant; round robin on a tie
                if (mprot_b && (cur.pend != 2'h0)) begin
                    next_cur.grant_lcl = cur.pend[1] && (!cur.pend[0] || !cur.last_lcl);
                    next_cur.last_lcl = next_cur.grant_lcl;
                    if (next_cur.grant_lcl) begin
                        next_cur.req = lcl_cmd;
                        next_cur.idx = dpe_index(lcl_cmd.addr, lcl_win);
                        next_cur.pend[1] = 1'b0;
                    end else begin
                        next_cur.req = sys_cmd;
                        next_cur.idx = dpe_index(sys_cmd.addr, sys_win);
                        next_cur.pend[0] = 1'b0;
                    end
                    next_cur.st = DPE_ST_CHECK;
                end
            end
            DPE_ST_CHECK: begin
                if (cur.req.wr) begin
                    next_cur.mem[cur.idx].data = new_data;
                    if (!cur.mode.diag) begin
                        next_cur.mem[cur.idx].chk = gen_wr;
                    end
                    if (cur.mode.syn_exam) begin
                        next_cur.log = {1'b0, gen_wr};
                    end
                    next_cur.sys_ack = !cur.grant_lcl;
                    next_cur.lcl_ack = cur.grant_lcl;
                    next_cur.st = DPE_ST_IDLE;
                end else begin
                    next_cur.rdata = cur.mode.correct ? fixed : cur_word.data;
                    if (cur.mode.syn_exam) begin
                        next_cur.log = {1'b0, syn};
                    end else if (rd_err) begin
                        next_cur.log = {row, code};
                    end
                    // set after the read-clear above, so a new error is not lost
                    if (rd_err && (cur.mode.int_any || rd_unc)) begin
                        next_cur.irq = 1'b1;
                    end
                    if (rd_err) begin
                        next_cur.cnt = CW'(DPE_ERR_CYC - 1);
                        next_cur.st = DPE_ST_STALL;
                    end else begin
                        next_cur.sys_ack = !cur.grant_lcl;
                        next_cur.lcl_ack = cur.grant_lcl;
                        next_cur.st = DPE_ST_IDLE;
                    end
                end
            end
            DPE_ST_STALL: begin
                if (cur.cnt == '0) begin
                    next_cur.sys_ack = !cur.grant_lcl;
                    next_cur.lcl_ack = cur.grant_lcl;
                    next_cur.st = DPE_ST_IDLE;
                end else begin
                    next_cur.cnt = cur.cnt - CW'(1);
                end
            end
            default: begin
                next_cur.st = DPE_ST_IDLE;
            end
        endcase
        // requests latch after the grant clear, so a new one wins
        if (sys_req && sys_hit && mprot_b) begin
            next_cur.pend[0] = 1'b1;
        end
        if (lcl_req && lcl_hit && mprot_b) begin
            next_cur.pend[1] = 1'b1;
        end
    end

    // state register; array clears to zero, whose check bits are also zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '0;
            cur.st <= DPE_ST_IDLE;
            cur.mode <= DPE_MODE_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from the state register
    assign sys_ack = cur.sys_ack;
    assign lcl_ack = cur.lcl_ack;
    assign sys_rdata = cur.rdata;
    assign lcl_rdata = cur.rdata;
    assign io_ack = cur.io_ack;
    assign io_rdata = cur.io_rdata;
    assign err_irq = cur.irq;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    logic chk_rd;
    assign chk_rd = (cur.st == DPE_ST_CHECK) && !cur.req.wr;

    property p_diag_keep;
        (cur.st == DPE_ST_CHECK) && cur.req.wr && cur.mode.diag |=> cur.mem[cur.idx].chk == $past(cur_word.chk);
    endproperty
    a_diag_keep: assert property (p_diag_keep) else $error("check bits written in diagnostic mode");

    property p_bit7;
        // a write wins over a read in the same cycle and leaves io_rdata alone
        io_ack && $past(io_rd) && !$past(io_wr) |-> io_rdata[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("log bit 7 read as zero");

    property p_err_wait;
        chk_rd && rd_err |=> !(sys_ack || lcl_ack) [*8] ##4 !(sys_ack || lcl_ack) ##1 (sys_ack || lcl_ack);
    endproperty
    a_err_wait: assert property (p_err_wait) else $error("error read ack not delayed by the wait");

    property p_clean_ack;
        chk_rd && !rd_err |=> (sys_ack || lcl_ack);
    endproperty
    a_clean_ack: assert property (p_clean_ack) else $error("clean read not acked next cycle");

    property p_irq_unc;
        chk_rd && rd_unc && !cur.mode.syn_exam |=> err_irq;
    endproperty
    a_irq_unc: assert property (p_irq_unc) else $error("no irq on uncorrectable error");

    property p_irq_single;
        chk_rd && rd_err && !rd_unc && !cur.mode.int_any && !err_irq |=> !err_irq;
    endproperty
    a_irq_single: assert property (p_irq_single) else $error("single error raised irq under strict policy");

    property p_nocorrect;
        chk_rd && !cur.mode.correct |=> sys_rdata == $past(cur_word.data);
    endproperty
    a_nocorrect: assert property (p_nocorrect) else $error("read data altered in non-correcting mode");

    property p_correct;
        chk_rd && cur.mode.correct |=> sys_rdata == $past(fixed);
    endproperty
    a_correct: assert property (p_correct) else $error("correcting mode returned wrong data");

    property p_protect;
        !mprot_b && (cur.st == DPE_ST_IDLE) |=> (cur.st == DPE_ST_IDLE);
    endproperty
    a_protect: assert property (p_protect) else $error("access granted under memory protect");

    property p_one_port;
        !(sys_ack && lcl_ack);
    endproperty
    a_one_port: assert property (p_one_port) else $error("both ports acked together");

    property p_log_row;
        chk_rd && rd_err && !cur.mode.syn_exam |=> cur.log == {$past(row), $past(code)};
    endproperty
    a_log_row: assert property (p_log_row) else $error("log not loaded with row and bit code");

    property p_syn_raw;
        chk_rd && cur.mode.syn_exam |=> cur.log == {1'b0, $past(syn)};
    endproperty
    a_syn_raw: assert property (p_syn_raw) else $error("raw syndrome not logged");

    property p_c_err;
        chk_rd && rd_err;
    endproperty
    c_err: cover property (p_c_err);

    property p_c_tie;
        (cur.st == DPE_ST_IDLE) && (cur.pend == 2'h3);
    endproperty
    c_tie: cover property (p_c_tie);

    property p_c_byte;
        (cur.st == DPE_ST_CHECK) && cur.req.wr && cur.req.byte_op;
    endproperty
    c_byte: cover property (p_c_byte);
endmodule

// >>> logic/dpe_pkg.sv
/*
 * constants, field layouts and carrier types of the dual-port ecc ram controller.
 * assumes one 50 MHz clock; all users import the whole package.
 */
package dpe_pkg;
    // timing: extra wait added to a read that finds an error
    localparam int DPE_CLK_NS = 20;
    localparam int DPE_ERR_WAIT_NS = 255;
    // longest time, so round down; 255 ns gives 12 cycles, never below one
    localparam int DPE_ERR_CYC = (DPE_ERR_WAIT_NS / DPE_CLK_NS) < 1 ? 1 : (DPE_ERR_WAIT_NS / DPE_CLK_NS);

    // address partitioning
    localparam int DPE_SYS_PAGE_LSB = 22;
    localparam int DPE_SYS_BLK_LSB = 14;
    localparam int DPE_LCL_BLK_LSB = 16;

    // i/o port presets picked by the board straps (values arbitrary)
    localparam int DPE_IO_PRESETS = 9;
    localparam logic [15:0] DPE_IO_TABLE [0:8] = '{16'h0030, 16'h0034, 16'h0038, 16'h003c, 16'h0040,
                                                    16'h0044, 16'h0048, 16'h004c, 16'h0050};

    // error log layout
    localparam logic [4:0] DPE_CODE_CHK = 5'h10;
    localparam logic [4:0] DPE_CODE_PAR = 5'h15;
    localparam logic [4:0] DPE_CODE_NOERR = 5'h1e;
    localparam logic [4:0] DPE_CODE_UNC = 5'h1f;
    localparam logic [4:0] DPE_DATA_CODES = 5'h10;

    // codeword position of each data bit, powers of two skipped for check bits
    localparam logic [4:0] DPE_POS [0:15] = '{5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0c,
                                              5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};

    // mode control register, bits 3..0 of an i/o write
    typedef struct packed {
        logic syn_exam;
        logic diag;
        logic correct;
        logic int_any;
    } dpe_mode_type;
    localparam dpe_mode_type DPE_MODE_RESET = 4'h3;

    // one bus request, held stable by the master until its ack
    typedef struct packed {
        logic wr;
        logic byte_op;
        logic [23:0] addr;
        logic [15:0] wdata;
    } dpe_req_type;

    typedef struct packed {
        logic [15:0] data;
        logic [5:0] chk;
    } dpe_word_type;

    typedef enum logic [2:0] {
        DPE_ST_IDLE = 3'h1,
        DPE_ST_CHECK = 3'h2,
        DPE_ST_STALL = 3'h4
    } dpe_st_type;
endpackage

// >>> tb/dpe_bus_master.sv
/*
 * behavioural bus master for one memory port of the ecc ram controller.
 * assumes the port answers a one-cycle request pulse with a one-cycle ack.
 */
`timescale 1ns/1ps
module dpe_bus_master
    import dpe_pkg::*;
(
    // clock
    input wire logic clock,
    // request side
    output dpe_req_type cmd,
    output logic req,
    // answer side
    input wire logic ack,
    input wire logic [15:0] rdata
);
    initial begin
        req = 1'b0;
        cmd = '0;
    end

    // one access: pulse req, hold cmd until ack, then scramble the released lines
    task automatic access(input logic wr, input logic byte_op, input logic [23:0] addr,
                          input logic [15:0] wdata, input int bound,
                          output logic [15:0] rd, output int cyc, output bit ok);
        ok = 0;
        cyc = 1;
        rd = '0;
        @(negedge clock);
        req <= 1'b1;
        cmd <= {wr, byte_op, addr, wdata};
        @(negedge clock);
        req <= 1'b0;
        // bounded wait; a refused request simply runs out
        while (cyc < bound && !ok) begin
            if (ack === 1'b1) begin
                ok = 1;
                rd = rdata;
            end else begin
                @(negedge clock);
                cyc++;
            end
        end
        // released lines must not keep the last value
        cmd <= ~cmd;
    endtask
endmodule

// >>> tb/dpe_ecc_ctrl_tb.sv
/*
 * self-checking bench for the dual-port ecc ram controller.
 * assumes WORD_BITS 8, preset i/o table and error wait from the package.
 */
`timescale 1ns/1ps
module dpe_ecc_ctrl_tb
    import dpe_pkg::*;
;
    localparam logic [23:0] SYS_B = 24'h410000;
    localparam logic [23:0] LCL_B = 24'h200000;
    localparam logic [23:0] W_OFS = 24'h00018a;
    logic clock, rst_b, mprot_b, sys_req, lcl_req, sys_ack, lcl_ack, io_rd, io_wr, io_ack, err_irq;
    dpe_req_type sys_cmd, lcl_cmd;
    logic [1:0] sys_page;
    logic [7:0] sys_base, lcl_base, io_wdata, io_rdata, r8;
    logic [3:0] io_sel;
    logic [15:0] io_addr, io_a, sys_rdata, lcl_rdata, r16, ra, rb;
    logic [5:0] ca, cc;
    int bad_count, checks_done, cyc, clean;
    bit ok;

    dpe_ecc_ctrl #(.WORD_BITS(8), .SPARE_IO_ADDR(16'h00f0)) i_dut (.clock(clock), .rst_b(rst_b),
        .sys_req(sys_req), .sys_cmd(sys_cmd), .sys_page(sys_page), .sys_base(sys_base), .sys_ack(sys_ack),
        .sys_rdata(sys_rdata), .lcl_req(lcl_req), .lcl_cmd(lcl_cmd), .lcl_base(lcl_base), .lcl_ack(lcl_ack),
        .lcl_rdata(lcl_rdata), .io_sel(io_sel), .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_ack(io_ack), .io_rdata(io_rdata), .mprot_b(mprot_b), .err_irq(err_irq));
    dpe_bus_master i_sys (.clock(clock), .cmd(sys_cmd), .req(sys_req), .ack(sys_ack), .rdata(sys_rdata));
    dpe_bus_master i_lcl (.clock(clock), .cmd(lcl_cmd), .req(lcl_req), .ack(lcl_ack), .rdata(lcl_rdata));

    always #10 clock = ~clock;

    task automatic complete_run;
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // a missing answer ends the run at once
    task automatic hang;
        bad_count++;
        $display("wrong value at %0t: no answer", $time);
        complete_run();
    endtask

    // hamming check bits plus overall parity, built from the bit positions
    function automatic logic [5:0] chk6(input logic [15:0] d);
        logic [5:0] c;
        c = '0;
        for (int i = 0; i < 16; i++)
            for (int k = 0; k < 5; k++)
                if (DPE_POS[i][k])
                    c[k] ^= d[i];
        c[5] = ^{d, c[4:0]};
        return c;
    endfunction

    // i/o port strobe; ack is sampled at the falling edge after the take
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output bit got);
        got = 0;
        rd = '0;
        @(negedge clock);
        io_wr <= wr;
        io_rd <= !wr;
        io_addr <= a;
        io_wdata <= wd;
        @(negedge clock);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        for (int n = 0; n < 3 && !got; n++)
            if (io_ack === 1'b1) begin
                got = 1;
                rd = io_rdata;
            end else
                @(negedge clock);
        io_addr <= ~a;
    endtask

    task automatic io_do(input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        bit got;
        io(wr, io_a, wd, rd, got);
        if (!got)
            hang();
    endtask

    task automatic mem(input bit lcl, input logic wr, input logic bo, input logic [23:0] a,
                       input logic [15:0] wd, output logic [15:0] rd, output int n);
        bit got;
        if (lcl)
            i_lcl.access(wr, bo, a, wd, 60, rd, n, got);
        else
            i_sys.access(wr, bo, a, wd, 60, rd, n, got);
        if (!got)
            hang();
    endtask

    initial begin
        clock = 0; rst_b = 0; mprot_b = 1; sys_page = 2'h1; sys_base = 8'h04; lcl_base = 8'h20;
        io_sel = 4'h2; io_rd = 0; io_wr = 0; io_addr = '0; io_wdata = '0; bad_count = 0; checks_done = 0;
        io_a = DPE_IO_TABLE[2];
        repeat (4) @(negedge clock);
        rst_b = 1;
        // empty log after reset, top bit set
        io_do(0, 8'h00, r8);
        check(r8, 16'h0080);
        check(err_irq, 0);
        io(1, 16'h0030, 8'h03, r8, ok);
        check(ok, 0);
        io_sel = 4'hc;
        io_a = 16'h00f0;
        io_do(1, 8'h03, r8);
        // word and byte traffic across both windows
        mem(0, 1, 0, SYS_B + 24'h10, 16'hbeef, r16, cyc);
        mem(1, 0, 0, LCL_B + 24'h10, 16'h0000, r16, cyc);
        check(r16, 16'hbeef);
        mem(1, 1, 1, LCL_B + 24'h11, 16'h5a00, r16, cyc);
        mem(0, 1, 1, SYS_B + 24'h10, 16'h0033, r16, cyc);
        mem(0, 0, 0, SYS_B + 24'h10, 16'h0000, r16, clean);
        check(r16, 16'h5a33);
        // refused: outside either window, and while protected
        i_sys.access(0, 0, 24'h010010, 16'h0000, 20, r16, cyc, ok);
        check(ok, 0);
        i_lcl.access(0, 0, 24'h1f0010, 16'h0000, 20, r16, cyc, ok);
        check(ok, 0);
        mprot_b = 0;
        i_sys.access(1, 0, SYS_B + 24'h10, 16'hdead, 20, r16, cyc, ok);
        check(ok, 0);
        mprot_b = 1;
        // both ports at once; the loser must still finish
        fork
            mem(0, 0, 0, SYS_B + 24'h10, 16'h0000, ra, cyc);
            mem(1, 1, 0, LCL_B + 24'h20, 16'h1111, rb, cyc);
        join
        check(ra, 16'h5a33);
        mem(1, 0, 0, LCL_B + 24'h20, 16'h0000, r16, cyc);
        check(r16, 16'h1111);
        // stale check bits give a single-bit error in data bit 5, row 3
        mem(0, 1, 0, SYS_B + W_OFS, 16'h1234, r16, cyc);
        io_do(1, 8'h07, r8);
        mem(0, 1, 0, SYS_B + W_OFS, 16'h1214, r16, cyc);
        io_do(1, 8'h03, r8);
        mem(0, 0, 0, SYS_B + W_OFS, 16'h0000, r16, cyc);
        check(r16, 16'h1234);
        check(16'(cyc), 16'(clean + DPE_ERR_CYC));
        check(err_irq, 1);
        io_do(0, 8'h00, r8);
        check(r8, 16'h00e5);
        check(err_irq, 0);
        // non-correcting keeps raw data but still interrupts
        io_do(1, 8'h01, r8);
        mem(0, 0, 0, SYS_B + W_OFS, 16'h0000, r16, cyc);
        check(r16, 16'h1214);
        check(err_irq, 1);
        io_do(0, 8'h00, r8);
        check(r8, 16'h00e5);
        // uncorrectable-only policy ignores single-bit errors
        io_do(1, 8'h02, r8);
        mem(0, 0, 0, SYS_B + W_OFS, 16'h0000, r16, cyc);
        check(r16, 16'h1234);
        check(err_irq, 0);
        // two flipped bits cannot be fixed
        io_do(1, 8'h06, r8);
        mem(0, 1, 0, SYS_B + W_OFS, 16'h1237, r16, cyc);
        io_do(1, 8'h02, r8);
        mem(0, 0, 0, SYS_B + W_OFS, 16'h0000, r16, cyc);
        check(r16, 16'h1237);
        check(err_irq, 1);
        io_do(0, 8'h00, r8);
        check(r8, 16'h00ff);
        // examine mode shows raw check word and syndrome
        io_do(1, 8'h0a, r8);
        mem(0, 1, 0, SYS_B + 24'h20, 16'hc3a5, r16, cyc);
        io_do(0, 8'h00, r8);
        check(r8, {8'h00, 2'b10, chk6(16'hc3a5)});
        mem(0, 0, 0, SYS_B + 24'h20, 16'h0000, r16, cyc);
        io_do(0, 8'h00, r8);
        check(r8, 16'h0080);
        ca = chk6(16'h1234);
        cc = chk6(16'h1237);
        mem(0, 0, 0, SYS_B + W_OFS, 16'h0000, r16, cyc);
        io_do(0, 8'h00, r8);
        check(r8, {8'h00, 2'b10, ^{16'h1237, ca}, ca[4:0] ^ cc[4:0]});
        complete_run();
    end
endmodule
